// *** hw/hcr_pkg.sv ***
// package for the half correction round inject block
package hcr_pkg;
   localparam int unsigned NUM_POS = 6;          // inject positions
   localparam int unsigned TIMER_W = 4;          // primary timer step width
   localparam int unsigned BURST_LEN = 5;        // pulses per burst
   localparam logic [3:0] STEP_WINDOW_OPEN = 4'h0;
   localparam logic [3:0] STEP_WINDOW_CLOSE = 4'h5;
   localparam int unsigned FIRST_STAGE_BIT = 0;  // timer first stage
   localparam int unsigned THIRD_STAGE_BIT = 2;  // timer third stage
   localparam int unsigned LAST_STAGE_BIT = 3;   // timer last stage
   localparam logic [2:0] BURST_CNT_RST = 3'h0;

   // timer view sampled from the primary timer
   typedef struct packed {
      logic [3:0] step;      // current step 0..15
      logic half_strobe;     // half-step strobe level
   } hcr_timer_type;

   // status of the injector
   typedef struct packed {
      logic window_open;     // pulse window flag
      logic once_done;       // once latch
      logic [2:0] burst_cnt; // pulses issued this burst
   } hcr_status_type;
endpackage : hcr_pkg

// *** hw/hcr_round_inject.sv ***
// half correction rounding injector for the decimal product counter
//
// Overview of operation
// - add five below last retained position
// - inject only into six lowest positions
// - each gate passes burst only when enabled
// - one five-pulse burst per computation, broadcast
// - burst merged with column shift increment path
// - window allowed only in sixth shift cycle
// - burst in first primary cycle of shift
// - window sets at step zero, last stage off
// - decode pulses at steps 5, 7, 13, 15
// - step five pulse clears window flag
// - decode runs always, acts only when set
// - window clear sets once latch blocking reentry
// - only cancel clears the once latch
// - each half strobe rise in the open window gives one pulse
// - driver feeds five pulses to all gates
`timescale 1ns/100ps
module hcr_round_inject (
   input wire logic clk,                                  // 100 MHz clock
   input wire logic rst_n,                                // sync reset, active low
   input wire hcr_pkg::hcr_timer_type timer_in,           // primary timer view
   input wire logic final_shift_cycle_indicator,          // sixth shift cycle active
   input wire logic first_primary_cycle,                  // first primary cycle of shift
   input wire logic cancel,                               // clears the once latch
   input wire logic [hcr_pkg::NUM_POS-1:0] inject_enable, // panel enables per position
   input wire logic [hcr_pkg::NUM_POS-1:0] shift_pulse,   // column shift pulses
   output logic [hcr_pkg::NUM_POS-1:0] counter_increment, // merged counter inputs
   output logic burst_driver,                             // broadcast burst pulse
   output hcr_pkg::hcr_status_type status                 // flag and latch view
);

   // synchronised copies of the timer pins
   logic [3:0] step_meta;
   logic [3:0] step_sync;
   logic strobe_meta;
   logic strobe_sync;
   logic [3:0] next_step_meta;
   logic [3:0] next_step_sync;
   logic next_strobe_meta;
   logic next_strobe_sync;
   // one cycle of edge history behind the synchronisers
   logic [3:0] step_prev;
   logic strobe_prev;
   logic next_strobe_prev;
   logic [3:0] next_step_prev;

   // two-flop synchronisers for the timer pins; the stage bits cross one by
   // one, which is safe because every decode below watches a single bit edge
   // while the other bits it reads stand still across that step change
   always_comb begin
      next_step_meta = timer_in.step;
      next_step_sync = step_meta;
      next_strobe_meta = timer_in.half_strobe;
      next_strobe_sync = strobe_meta;
   end

   // synchroniser registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         step_meta <= 4'h0;
         step_sync <= 4'h0;
         strobe_meta <= 1'b0;
         strobe_sync <= 1'b0;
      end else begin
         step_meta <= next_step_meta;
         step_sync <= next_step_sync;
         strobe_meta <= next_strobe_meta;
         strobe_sync <= next_strobe_sync;
      end
   end

   // edge history of the synchronised timer
   always_comb begin
      next_step_prev = step_sync;
      next_strobe_prev = strobe_sync;
   end

   // edge history registers, cleared with the synchronisers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         step_prev <= 4'h0;
         strobe_prev <= 1'b0;
      end else begin
         step_prev <= next_step_prev;
         strobe_prev <= next_strobe_prev;
      end
   end

   // timer stage views and the blocking terms of the window flag
   logic timer_last_stage;
   logic timer_last_stage_off;
   logic timer_first_stage_on;
   logic timer_third_stage;
   logic step_decode_gate;
   logic strobe_rise;
   logic early_cycle_blocker;
   logic once_latch_blocker;

   // timer stage decode; step zero counts as third stage on, which only
   // matters with a first stage rise, so a skewed step word never decodes
   always_comb begin
      timer_last_stage = step_sync[hcr_pkg::LAST_STAGE_BIT];
      timer_last_stage_off = step_prev[hcr_pkg::LAST_STAGE_BIT] & ~timer_last_stage;
      timer_first_stage_on = ~step_prev[hcr_pkg::FIRST_STAGE_BIT]
         & step_sync[hcr_pkg::FIRST_STAGE_BIT];
      timer_third_stage = step_sync[hcr_pkg::THIRD_STAGE_BIT]
         | (step_sync == hcr_pkg::STEP_WINDOW_OPEN);
      step_decode_gate = timer_first_stage_on & timer_third_stage;
      strobe_rise = strobe_sync & ~strobe_prev;
   end

   // control state of the injector and its next values
   logic pulse_window_flag;
   logic once_latch;
   logic [2:0] burst_cnt;
   logic next_pulse_window_flag;
   logic next_once_latch;
   logic [2:0] next_burst_cnt;
   logic window_set;
   logic window_clear;
   logic strobe_burst_gate;
   logic next_burst_driver;
   wire logic [hcr_pkg::NUM_POS-1:0] position_inject_gate;
   wire logic [hcr_pkg::NUM_POS-1:0] next_counter_increment;
   hcr_pkg::hcr_status_type next_status;

   // window flag: opens at step zero of the gated cycle, closes at the first
   // decode pulse; the later decode pulses find it closed and do nothing
   always_comb begin
      early_cycle_blocker = ~final_shift_cycle_indicator;
      once_latch_blocker = once_latch;
      window_clear = pulse_window_flag & step_decode_gate;
      window_set = ~pulse_window_flag & timer_last_stage_off & first_primary_cycle
         & ~early_cycle_blocker & ~once_latch_blocker;
      next_pulse_window_flag = pulse_window_flag;
      if (window_clear) begin
         next_pulse_window_flag = 1'b0;
      end else if (window_set) begin
         next_pulse_window_flag = 1'b1;
      end
   end

   // window flag register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_window_flag <= 1'b0;
      end else begin
         pulse_window_flag <= next_pulse_window_flag;
      end
   end

   // once latch: set as the window closes and cleared only by cancel; a cancel
   // in the closing cycle loses, so a burst always leaves the latch set
   always_comb begin
      next_once_latch = once_latch;
      if (window_clear) begin
         next_once_latch = 1'b1;
      end else if (cancel) begin
         next_once_latch = 1'b0;
      end
   end

   // once latch register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         once_latch <= 1'b0;
      end else begin
         once_latch <= next_once_latch;
      end
   end

   // burst counter and strobe gate; the cap is only a guard, since the
   // window itself spans exactly five strobe rises
   always_comb begin
      strobe_burst_gate = pulse_window_flag & strobe_rise
         & (burst_cnt < 3'(hcr_pkg::BURST_LEN));
      next_burst_cnt = burst_cnt;
      if (window_set) begin
         next_burst_cnt = hcr_pkg::BURST_CNT_RST;
      end else if (strobe_burst_gate) begin
         next_burst_cnt = burst_cnt + 3'h1;
      end
   end

   // burst counter register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         burst_cnt <= hcr_pkg::BURST_CNT_RST;
      end else begin
         burst_cnt <= next_burst_cnt;
      end
   end

   // one inject gate per low-order position; each passes the broadcast burst
   // only when its panel enable is wired, and shares the shift path input
   for (genvar g = 0; g < hcr_pkg::NUM_POS; g++) begin : gen_pos_gate
      assign position_inject_gate[g] = strobe_burst_gate & inject_enable[g];
      assign next_counter_increment[g] = shift_pulse[g] | position_inject_gate[g];
   end

   // driver stage and status view, registered so every port leaves a flop
   always_comb begin
      next_burst_driver = strobe_burst_gate;
      next_status.window_open = next_pulse_window_flag;
      next_status.once_done = next_once_latch;
      next_status.burst_cnt = next_burst_cnt;
   end

   // output registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         burst_driver <= 1'b0;
         counter_increment <= '0;
         status <= '0;
      end else begin
         burst_driver <= next_burst_driver;
         counter_increment <= next_counter_increment;
         status <= next_status;
      end
   end

endmodule : hcr_round_inject

// *** sim/hcr_round_inject_monitor.sv ***
// port checker for the rounding injector
`timescale 1ns/100ps
module hcr_round_inject_monitor (
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset, active low
   input wire logic cancel, // clears the once latch
   input wire logic first_primary_cycle, // first primary cycle of shift
   input wire logic final_shift_cycle_indicator, // sixth shift cycle active
   input wire logic burst_driver, // broadcast burst pulse
   input wire hcr_pkg::hcr_timer_type timer_in, // timer view
   input wire logic [hcr_pkg::NUM_POS-1:0] inject_enable, // panel enables
   input wire logic [hcr_pkg::NUM_POS-1:0] shift_pulse, // column shift pulses
   input wire logic [hcr_pkg::NUM_POS-1:0] counter_increment, // merged counter inputs
   input wire hcr_pkg::hcr_status_type status // flag and latch
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic win = status.window_open; // window flag alias
   chk_merge_path: assert property (counter_increment ==
      ($past(shift_pulse) | {hcr_pkg::NUM_POS{burst_driver}} & $past(inject_enable)))
      else $error("merge");
   chk_early_block: assert property ($rose(win) |-> $past(final_shift_cycle_indicator))
      else $error("early open");
   chk_first_cycle: assert property ($rose(win) |-> $past(first_primary_cycle))
      else $error("late open");
   chk_open_step: assert property ($rose(win) |-> $past(timer_in.step) == 4'h0)
      else $error("open step");
   chk_close_step: assert property ($fell(win) |-> $past(timer_in.step) == 4'h5)
      else $error("close step");
   chk_once_block: assert property ($rose(win) |-> !$past(status.once_done))
      else $error("reentry");
   chk_latch_set: assert property ($fell(win) |-> ##[0:1] status.once_done)
      else $error("latch set");
   chk_latch_hold: assert property (status.once_done && !cancel |=> status.once_done)
      else $error("latch drop");
   chk_burst_gate: assert property (burst_driver |-> $past(win))
      else $error("stray pulse");
   chk_single_pulse: assert property (burst_driver |=> !burst_driver)
      else $error("wide pulse");
endmodule : hcr_round_inject_monitor
bind hcr_round_inject hcr_round_inject_monitor mon (.*);

// *** sim/hcr_round_inject_tb_top.sv ***
// self-checking bench for the rounding injector
`timescale 1ns/100ps
module hcr_round_inject_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, cancel = 1'b0, first_primary_cycle = 1'b0;
   logic final_shift_cycle_indicator = 1'b0, burst_driver;
   logic [5:0] inject_enable = 6'h00, shift_pulse = 6'h00, counter_increment;
   hcr_pkg::hcr_timer_type timer_in;
   hcr_pkg::hcr_status_type status;
   int error_cnt = 0, check_count = 0, cyc = 0;
   logic [7:0] nb;
   logic [7:0] np [6];
   // rows of {final, first, enables, expected pulsing positions, expected burst count}
   logic [21:0] rows [5] = '{22'h304105, 22'h1fc000, 22'h2fc000, 22'h3aaa05, 22'h3fff05};
   hcr_round_inject dut (.*);
   hcr_timer_model tmr (.clk(clk), .timer_in(timer_in));
   initial forever #5 clk = ~clk;
   // cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [7:0] got, exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic run(input logic [7:0] r, input logic clr);
      @(posedge clk) #1;
      cancel = clr;
      {final_shift_cycle_indicator, first_primary_cycle, inject_enable} = r;
      nb = 8'h00;
      np = '{default: 8'h00};
      @(posedge clk) #1 cancel = 1'b0;
      // count every one-cycle pulse once, sampled after the launching edge
      repeat (300) begin
         if (burst_driver === 1'b1) nb = nb + 8'h01;
         foreach (np[i]) if (counter_increment[i] === 1'b1) np[i] = np[i] + 8'h01;
         @(posedge clk) #1;
      end
      final_shift_cycle_indicator = 1'b0;
   endtask : run
   task automatic report_and_stop;
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // table rows, then latch and merge cases
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      chk({3'h0, status}, 8'h00);
      foreach (rows[k]) begin
         run(rows[k][21:14], 1'b1);
         chk(nb, rows[k][7:0]);
         foreach (np[i]) chk(np[i], rows[k][8 + i] ? rows[k][7:0] : 8'h00);
      end
      run(8'hff, 1'b0);
      chk(nb, 8'h00);
      chk({7'h0, status.once_done}, 8'h01);
      shift_pulse = 6'h15;
      @(posedge clk) #1 shift_pulse = 6'h00;
      chk({2'h0, counter_increment}, 8'h15);
      @(posedge clk) #1;
      chk({2'h0, counter_increment}, 8'h00);
      report_and_stop();
   end
endmodule : hcr_round_inject_tb_top

// *** sim/hcr_timer_model.sv ***
// free running primary timer with half-step strobe
`timescale 1ns/100ps
module hcr_timer_model (
   input wire logic clk, // clock
   output hcr_pkg::hcr_timer_type timer_in // step and strobe
);
   logic [6:0] t = 7'h00;
   // eight clocks a step, strobe high in the second half of each step
   always_ff @(posedge clk) t <= t + 7'h01;
   assign timer_in = {t[6:3], t[2]};
endmodule : hcr_timer_model
